// >>> design/amq_pkg.sv
// Constants, types and field layouts for the analog modulation state query responder.
// Assumes a byte-wide command link that is framed elsewhere on the same clock.
// Notes on behaviour
// - Reply: address, status, state, checksum high, low.
// - State byte reports current analog modulation setting.
// - State byte: 0 disabled, 1 enabled.
// - Not ready: status, checksum, then one fill byte.
package amq_pkg;

    localparam int          BYTE_W       = 8;
    localparam int          REQ_LEN      = 4;
    localparam int          RESP_LEN     = 5;
    localparam int          IDX_W        = 3;
    localparam int          CNT_W        = 3;
    localparam int          ERR_BITS     = 29;
    localparam int          WARN_BITS    = 14;

    localparam logic [7:0]  CMD_QUERY_ANALOG_MOD  = 8'h66;
    localparam logic [7:0]  MOD_STATE_OFF         = 8'h00;
    localparam logic [7:0]  MOD_STATE_ON          = 8'h01;

    // Link addresses, checksum settings and fill value are plain parameter defaults.
    localparam logic [7:0]  DEF_WRITE_ADDRESS     = 8'h10;
    localparam logic [7:0]  DEF_READ_ADDRESS      = 8'h11;
    localparam logic [15:0] DEF_CRC_POLY          = 16'h1021;
    localparam logic [15:0] DEF_CRC_INIT          = 16'hFFFF;
    localparam logic [7:0]  DEF_FILL_BYTE         = 8'h00;

    // Byte positions inside the request frame, its idle index and the last reply byte index.
    localparam logic [2:0]  REQ_IDX_ADDR   = 3'h0;
    localparam logic [2:0]  REQ_IDX_CMD    = 3'h1;
    localparam logic [2:0]  REQ_IDX_CRC_HI = 3'h2;
    localparam logic [2:0]  REQ_IDX_CRC_LO = 3'h3;
    localparam logic [2:0]  REQ_IDX_IDLE   = 3'h4;
    localparam logic [2:0]  RESP_IDX_LAST  = 3'h4;

    // One byte on the link; sof marks the first byte of a frame.
    typedef struct packed {
        logic       sof;
        logic       valid;
        logic [7:0] data;
    } amq_byte_s;

    typedef struct packed {
        logic [ERR_BITS-1:0]  error;
        logic [WARN_BITS-1:0] warning;
    } amq_flags_s;

    typedef enum logic {
        ST_RECV,
        ST_SEND
    } amq_state_e;

endpackage

// >>> design/amq_responder.sv
// Responder for the analog modulation state query on the command link.
// Assumes request bytes and response handshake come from logic on clk.
`timescale 1ns/1ps

module amq_responder #(
    parameter logic [7:0]  DEVICE_WRITE_ADDRESS = amq_pkg::DEF_WRITE_ADDRESS,
    parameter logic [7:0]  DEVICE_READ_ADDRESS  = amq_pkg::DEF_READ_ADDRESS,
    parameter logic [15:0] CRC_POLY             = amq_pkg::DEF_CRC_POLY,
    parameter logic [15:0] CRC_INIT             = amq_pkg::DEF_CRC_INIT,
    parameter logic [7:0]  FILL_BYTE            = amq_pkg::DEF_FILL_BYTE
) (
    // Clock and reset.
    input  wire logic                           clk,
    input  wire logic                           reset,
    // Request bytes from the host.
    input  wire amq_pkg::amq_byte_s             rx_in,
    output wire logic                           rx_ready,
    // Response bytes to the host.
    output wire amq_pkg::amq_byte_s             tx_out,
    input  wire logic                           tx_ready,
    // Module state.
    input  wire logic [7:0]                     system_status,
    input  wire logic                           analog_mod_enable,
    input  wire logic                           data_available,
    // Error and warning flags.
    input  wire logic [amq_pkg::ERR_BITS-1:0]   error_set,
    input  wire logic [amq_pkg::WARN_BITS-1:0]  warning_set,
    input  wire logic                           flags_clear,
    output wire amq_pkg::amq_flags_s            flags_out,
    // One-cycle pulse when a valid query is taken.
    output wire logic                           request_taken
);
    import amq_pkg::*;

    function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] b);
        logic [15:0] c;
        c = crc ^ {b, 8'h00};
        for (int i = 0; i < BYTE_W; i++) begin
            c = c[15] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    amq_state_e                     state_reg;
    logic [IDX_W-1:0]               idx_reg;
    logic [15:0]                    crc_reg;
    logic [7:0]                     hi_reg;
    logic                           bad_reg;
    logic [RESP_LEN-1:0][7:0]       resp_reg;
    logic [CNT_W-1:0]               cnt_reg;
    amq_flags_s                     flags_reg;

    // Request decoding.
    wire                rx_take   = rx_in.valid && (state_reg == ST_RECV);
    wire [IDX_W-1:0]    idx_cur   = rx_in.sof ? REQ_IDX_ADDR : idx_reg;
    wire [15:0]         crc_base  = rx_in.sof ? CRC_INIT : crc_reg;
    wire                bad_base  = rx_in.sof ? 1'b0 : bad_reg;
    wire                addr_bad  = (idx_cur == REQ_IDX_ADDR) && (rx_in.data != DEVICE_WRITE_ADDRESS);
    wire                cmd_bad   = (idx_cur == REQ_IDX_CMD) && (rx_in.data != CMD_QUERY_ANALOG_MOD);
    wire                bad_next  = bad_base | addr_bad | cmd_bad;
    wire                crc_match = ({hi_reg, rx_in.data} == crc_reg);
    wire                req_ok    = rx_take && (idx_cur == REQ_IDX_CRC_LO) && !bad_next
                                    && crc_match;

    // Response building.
    wire [7:0]          mod_byte  = analog_mod_enable ? MOD_STATE_ON
                                                      : MOD_STATE_OFF;
    wire [15:0]         crc_a     = crc16_byte(CRC_INIT, DEVICE_READ_ADDRESS);
    wire [15:0]         crc_s     = crc16_byte(crc_a, system_status);
    wire [15:0]         crc_m     = crc16_byte(crc_s, mod_byte);
    wire [RESP_LEN-1:0][7:0] resp_full  = {crc_m[7:0], crc_m[15:8], mod_byte,
                                           system_status, DEVICE_READ_ADDRESS};
    wire [RESP_LEN-1:0][7:0] resp_short = {FILL_BYTE, crc_s[7:0], crc_s[15:8],
                                           system_status, DEVICE_READ_ADDRESS};
    wire                tx_fire   = (state_reg == ST_SEND) && tx_ready;
    wire                tx_last   = tx_fire && (cnt_reg == RESP_IDX_LAST);

    assign rx_ready      = (state_reg == ST_RECV);
    assign tx_out.sof    = (state_reg == ST_SEND) && (cnt_reg == '0);
    assign tx_out.valid  = (state_reg == ST_SEND);
    assign tx_out.data   = resp_reg[0];
    assign flags_out     = flags_reg;
    assign request_taken = req_ok;

    // Request receiver: checks address, command and checksum byte by byte.
    always_ff @(posedge clk) begin
        if (reset) begin
            idx_reg <= REQ_IDX_IDLE;
            crc_reg <= CRC_INIT;
            hi_reg  <= 8'h00;
            bad_reg <= 1'b0;
        end else if (rx_take && (idx_cur != REQ_IDX_IDLE)) begin
            idx_reg <= idx_cur + 3'h1;
            bad_reg <= bad_next;
            if (idx_cur == REQ_IDX_CRC_HI) begin
                hi_reg <= rx_in.data;
            end
            if (idx_cur < REQ_IDX_CRC_HI) begin
                crc_reg <= crc16_byte(crc_base, rx_in.data);
            end
        end
    end

    // Response sender: shifts the captured reply out one byte per accepted handshake.
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= ST_RECV;
            resp_reg  <= '0;
            cnt_reg   <= '0;
        end else begin
            case (state_reg)
                ST_RECV: begin
                    if (req_ok) begin
                        state_reg <= ST_SEND;
                        cnt_reg   <= '0;
                        resp_reg  <= data_available ? resp_full : resp_short;
                    end
                end
                ST_SEND: begin
                    if (tx_fire) begin
                        resp_reg <= {8'h00, resp_reg[RESP_LEN-1:1]};
                        cnt_reg  <= cnt_reg + 3'h1;
                        if (tx_last) begin
                            state_reg <= ST_RECV;
                        end
                    end
                end
                default: begin
                    state_reg <= ST_RECV;
                end
            endcase
        end
    end

    // Flags stay set until cleared; a set in the clearing cycle wins.
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_reg <= '0;
        end else begin
            flags_reg.error   <= (flags_clear ? '0 : flags_reg.error) | error_set;
            flags_reg.warning <= (flags_clear ? '0 : flags_reg.warning) | warning_set;
        end
    end

    a_reply_opens_addr: assert property (
        @(posedge clk) disable iff (reset)
        req_ok |=> tx_out.valid && tx_out.sof && (tx_out.data == DEVICE_READ_ADDRESS))
        else $error("Reply does not open with the read address.");

    a_reply_status_byte: assert property (
        @(posedge clk) disable iff (reset)
        req_ok |=> (resp_reg[1] == $past(system_status)))
        else $error("Second reply byte is not the system status.");

    a_reply_mod_state: assert property (
        @(posedge clk) disable iff (reset)
        req_ok && data_available |=> (resp_reg[2][0] == $past(analog_mod_enable)))
        else $error("State byte does not follow the modulation setting.");

    a_mod_state_code: assert property (
        @(posedge clk) disable iff (reset)
        req_ok && data_available |=>
            (resp_reg[2] == ($past(analog_mod_enable) ? 8'h01 : 8'h00)))
        else $error("State byte is not coded as 0 or 1.");

    a_short_reply_fill: assert property (
        @(posedge clk) disable iff (reset)
        req_ok && !data_available |=>
            (resp_reg[4] == FILL_BYTE) && ({resp_reg[2], resp_reg[3]} == $past(crc_s)))
        else $error("Unready reply lacks checksum after status or fill.");

    // Bytes accepted since the last request, counted apart from the sender's own counter.
    logic [CNT_W-1:0]               sent_reg;

    always_ff @(posedge clk) begin
        if (reset || req_ok) begin
            sent_reg <= '0;
        end else if (tx_fire) begin
            sent_reg <= sent_reg + 3'h1;
        end
    end

    a_reply_length: assert property (
        @(posedge clk) disable iff (reset)
        tx_fire && (sent_reg == RESP_IDX_LAST) |=> !tx_out.valid && rx_ready)
        else $error("Reply does not end after the fifth byte.");

    a_reply_not_short: assert property (
        @(posedge clk) disable iff (reset)
        tx_fire && (sent_reg < RESP_IDX_LAST) |=> tx_out.valid && !tx_out.sof)
        else $error("Reply ends early or repeats its first byte.");

    a_reply_byte_holds: assert property (
        @(posedge clk) disable iff (reset)
        tx_out.valid && !tx_ready |=> tx_out.valid && $stable(tx_out.data))
        else $error("Reply byte changed before it was accepted.");

    a_flag_set_wins: assert property (
        @(posedge clk) disable iff (reset)
        (error_set != '0) |=> ((flags_out.error & $past(error_set)) == $past(error_set)))
        else $error("Error flag set was lost.");

    a_flag_clear: assert property (
        @(posedge clk) disable iff (reset)
        flags_clear && (error_set == '0) && (warning_set == '0) |=> (flags_out == '0))
        else $error("Flags did not clear.");

    a_bad_cmd_ignored: assert property (
        @(posedge clk) disable iff (reset)
        rx_take && (idx_cur == REQ_IDX_CMD) && (rx_in.data != CMD_QUERY_ANALOG_MOD)
        ##1 rx_in.valid [*2] |-> !req_ok)
        else $error("Wrong command code was answered.");

    a_bad_addr_ignored: assert property (
        @(posedge clk) disable iff (reset)
        rx_take && rx_in.sof && (rx_in.data != DEVICE_WRITE_ADDRESS)
        ##1 (rx_in.valid && !rx_in.sof) [*3] |-> !req_ok)
        else $error("Frame for another address was answered.");

    a_busy_refuses_rx: assert property (
        @(posedge clk) disable iff (reset)
        tx_out.valid |-> !rx_ready && !request_taken)
        else $error("Request taken while a reply is pending.");

    a_taken_one_cycle: assert property (
        @(posedge clk) disable iff (reset)
        request_taken |=> !request_taken && !rx_ready)
        else $error("Taken pulse is longer than one cycle.");

endmodule

// >>> verif/amq_host_model.sv
// Host controller model that sends framed requests and collects the replies.
// Assumes the responder runs on the same clk; all drives change at falling edges.
`timescale 1ns/1ps

module amq_host_model (
    // Clock.
    input  wire logic               clk,
    // Request bytes to the responder.
    output amq_pkg::amq_byte_s      rx_in,
    input  wire logic               rx_ready,
    // Reply bytes from the responder.
    input  wire amq_pkg::amq_byte_s tx_out,
    output logic                    tx_ready
);
    import amq_pkg::*;
    logic [7:0] rep [RESP_LEN];
    logic       first_sof;
    bit         slow;
    logic [7:0] wr_addr;

    initial begin
        rx_in    = '0;
        tx_ready = 1'b0;
        slow     = 1'b0;
        wr_addr  = DEF_WRITE_ADDRESS;
    end

    function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] b);
        c = c ^ {b, 8'h00};
        for (int i = 0; i < 8; i++) begin
            c = c[15] ? ((c << 1) ^ DEF_CRC_POLY) : (c << 1);
        end
        return c;
    endfunction

    // A nonzero flip corrupts the checksum on purpose; wr_addr can aim at another device.
    // Ready is looked at on the falling edge, where it is settled, and the byte is taken
    // at the rising edge that follows.
    task automatic query(input logic [7:0] cmd, input logic [15:0] flip);
        logic [15:0] c;
        logic [7:0]  b [REQ_LEN];
        c = crc_step(crc_step(DEF_CRC_INIT, wr_addr), cmd) ^ flip;
        b = '{wr_addr, cmd, c[15:8], c[7:0]};
        for (int i = 0; i < REQ_LEN; i++) begin
            @(negedge clk);
            rx_in = '{sof: (i == 0), valid: 1'b1, data: b[i]};
            while (!rx_ready) @(negedge clk);
            @(posedge clk);
        end
        @(negedge clk);
        rx_in = '{sof: 1'b0, valid: 1'b0, data: ~b[REQ_LEN-1]};
    endtask

    // Slow mode withholds acceptance for two cycles before every byte.
    task automatic collect();
        for (int i = 0; i < RESP_LEN; i++) begin
            @(negedge clk);
            if (slow) begin
                tx_ready = 1'b0;
                repeat (2) @(negedge clk);
            end
            tx_ready = 1'b1;
            while (!tx_out.valid) @(negedge clk);
            rep[i] = tx_out.data;
            if (i == 0) first_sof = tx_out.sof;
            @(posedge clk);
        end
        @(negedge clk);
        tx_ready = 1'b0;
    endtask
endmodule

// >>> verif/analog_mod_status_query_tb.sv
// Self-checking bench for the analog modulation state query responder.
// Assumes the package, the responder and the host model are compiled first.
`timescale 1ns/1ps

module analog_mod_status_query_tb;
    import amq_pkg::*;
    logic                 clk;
    logic                 reset;
    amq_byte_s            rx_in;
    amq_byte_s            tx_out;
    logic                 rx_ready;
    logic                 tx_ready;
    logic [7:0]           system_status;
    logic                 analog_mod_enable;
    logic                 data_available;
    logic [ERR_BITS-1:0]  error_set;
    logic [WARN_BITS-1:0] warning_set;
    logic                 flags_clear;
    amq_flags_s           flags_out;
    logic                 request_taken;
    int                   n_errors = 0;
    int                   comparisons = 0;
    int                   cycles = 0;
    int                   n_taken = 0;

    amq_responder i_amq_responder (.clk(clk), .reset(reset), .rx_in(rx_in),
        .rx_ready(rx_ready), .tx_out(tx_out), .tx_ready(tx_ready),
        .system_status(system_status), .analog_mod_enable(analog_mod_enable),
        .data_available(data_available), .error_set(error_set),
        .warning_set(warning_set), .flags_clear(flags_clear),
        .flags_out(flags_out), .request_taken(request_taken));
    amq_host_model i_amq_host_model (.clk(clk), .rx_in(rx_in), .rx_ready(rx_ready),
        .tx_out(tx_out), .tx_ready(tx_ready));

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("errors=%0d comparisons=%0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic run_query(input logic mod, input logic avail, input logic [7:0] st);
        logic [15:0] c;
        logic [7:0]  m;
        int          t0;
        m = mod ? MOD_STATE_ON : MOD_STATE_OFF;
        c = i_amq_host_model.crc_step(i_amq_host_model.crc_step(DEF_CRC_INIT,
            DEF_READ_ADDRESS), st);
        if (avail) c = i_amq_host_model.crc_step(c, m);
        @(negedge clk);
        analog_mod_enable = mod;
        data_available = avail;
        system_status = st;
        t0 = n_taken;
        i_amq_host_model.query(CMD_QUERY_ANALOG_MOD, 16'h0000);
        check(n_taken - t0, 1);
        check(rx_ready, 0);
        check(tx_out.valid, 1);
        i_amq_host_model.collect();
        check(rx_ready, 1);
        check(tx_out.valid, 0);
        check(i_amq_host_model.first_sof, 1);
        check(i_amq_host_model.rep[0], DEF_READ_ADDRESS);
        check(i_amq_host_model.rep[1], st);
        if (avail) begin
            check(i_amq_host_model.rep[2], m);
            check({i_amq_host_model.rep[3], i_amq_host_model.rep[4]}, c);
        end else begin
            check({i_amq_host_model.rep[2], i_amq_host_model.rep[3]}, c);
            check(i_amq_host_model.rep[4], DEF_FILL_BYTE);
        end
    endtask

    // Absence of a reply can only be judged after a fixed quiet spell.
    task automatic run_refused(input logic [7:0] cmd, input logic [15:0] flip);
        int t0;
        t0 = n_taken;
        i_amq_host_model.query(cmd, flip);
        repeat (8) @(negedge clk);
        check(n_taken - t0, 0);
        check(tx_out.valid, 0);
    endtask

    task automatic run_flags();
        @(negedge clk);
        error_set = 29'h1000_0000;
        warning_set = 14'h0001;
        @(negedge clk);
        warning_set = '0;
        error_set = 29'h0000_0001;
        flags_clear = 1'b1;
        check(flags_out, {29'h1000_0000, 14'h0001});
        @(negedge clk);
        error_set = '0;
        check(flags_out, {29'h0000_0001, 14'h0000});
        @(negedge clk);
        flags_clear = 1'b0;
        check(flags_out, '0);
    endtask

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (request_taken === 1'b1) n_taken++;
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            wrap_up();
        end
    end

    initial begin
        reset = 1'b1;
        system_status = 8'h00;
        analog_mod_enable = 1'b0;
        data_available = 1'b1;
        error_set = '0;
        warning_set = '0;
        flags_clear = 1'b0;
        repeat (20) @(negedge clk);
        reset = 1'b0;
        check(rx_ready, 1);
        check(tx_out, '0);
        run_query(1'b0, 1'b1, 8'hA5);
        run_query(1'b1, 1'b1, 8'h3C);
        run_query(1'b1, 1'b0, 8'h5A);
        run_refused(8'h68, 16'h0000);
        run_refused(CMD_QUERY_ANALOG_MOD, 16'h0001);
        i_amq_host_model.wr_addr = DEF_READ_ADDRESS;
        run_refused(CMD_QUERY_ANALOG_MOD, 16'h0000);
        i_amq_host_model.wr_addr = DEF_WRITE_ADDRESS;
        i_amq_host_model.slow = 1'b1;
        run_query(1'b1, 1'b1, 8'hFF);
        run_query(1'b0, 1'b0, 8'h81);
        i_amq_host_model.slow = 1'b0;
        run_flags();
        wrap_up();
    end
endmodule
